/* core/sleep_wake_pkg.sv */
// Shared constants, state codes and the register request carrier.
// Assumes a 50 MHz system clock and an 8-bit register port.
package sleep_wake_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DISCHARGE_CFG = 8'h05;
  localparam logic [7:0] ADDR_CHARGE_CFG = 8'h06;
  localparam logic [7:0] ADDR_FEATURE_CFG = 8'h07;
  localparam logic [7:0] ADDR_UNLOCK = 8'h08;
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h09;
  localparam logic [7:0] ADDR_WAKE_STATUS = 8'h0A;

  // Field positions in the write-unlock register
  localparam int UNLOCK_FEAT_BIT = 7;
  localparam int UNLOCK_CHARGE_BIT = 6;
  localparam int UNLOCK_DISCH_BIT = 5;
  localparam int FLAG_UPPER_BIT = 4;
  localparam int FLAG_LOWER_BIT = 3;
  localparam logic [7:0] UNLOCK_RW_MASK = 8'hF8;

  // Field positions in the feature configuration register
  localparam int FEAT_FORCE_POR_BIT = 2;
  localparam int FEAT_WAKE_DISABLE_BIT = 1;
  localparam int FEAT_WAKE_POL_BIT = 0;

  // Own control and status fields
  localparam int SLEEP_BIT = 0;
  localparam int WAKE_STATUS_BIT = 0;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // Timing
  localparam int CLK_FREQ_MHZ = 50;
  localparam int WAKE_FILTER_TIME_NS = 1000;
  localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    AWAKE = 2'b01,
    ASLEEP = 2'b10,
    PSEUDO_SLEEP = 2'b11
  } power_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_s;

endpackage

/* core/wake_filter.sv */
// Glitch filter for the wake input's active level.
// Assumes the input is synchronous to clk_in.
`timescale 1ns/10ps
module wake_filter #(
  parameter int FILTER_CYCLES = 50
) (
  // Clock and clear
  input wire logic clk_in,
  input wire logic rst_in,
  // Level in and out
  input wire logic active_raw_in,
  output logic active_out
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FILTER_CYCLES - 1);

  logic [CW-1:0] cnt_ff;

  // Output follows the input only after it has differed for the whole filter time
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      active_out <= 1'b0;
    end else if (active_raw_in == active_out) begin
      cnt_ff <= '0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
      active_out <= active_raw_in;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  property p_filter_hold;
    @(posedge clk_in) disable iff (rst_in)
    $rose(active_out) |-> $past(active_raw_in, 1) && $past(active_raw_in, FILTER_CYCLES);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("wake passed a short pulse");

endmodule

/* core/sleep_wake_and_write_lock.sv */
// Sleep and wake sequencer with configuration write protection.
// Assumes register requests and pins are synchronous to clk_in.
// What this block does
// - Feature config writes need unlock bit 7.
// - Charge config writes need unlock bit 6.
// - Discharge config writes need unlock bit 5.
// - Unlock bits clear on power-up.
// - Bits 4 and 3 are free user flags.
// - User flags survive sleep but clear on supply loss.
// - Bits 2 to 0 are reserved.
// - Wake when both supplies pass threshold.
// - Stay awake until sleep or supply loss.
// - Polarity zero wakes on low input.
// - Active-low sleep entry needs rearm when active.
// - Polarity one wakes on high input.
// - Active-high sleep entry needs rearm when active.
// - Short wake pulses are filtered out.
// - Wake passes pseudo-sleep before full activity.
// - Wake status rise clears sleep bit.
// - Feature bit 0 selects wake polarity.
// - Feature bit 1 disables wake input.
`timescale 1ns/10ps
module sleep_wake_and_write_lock
  import sleep_wake_pkg::*;
#(
  parameter int FILTER_CYCLES = WAKE_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Supply monitors
  input wire logic backup_supply_ok_in,
  input wire logic main_supply_ok_in,
  // Wake pin
  input wire logic wake_input_in,
  // Register port
  input wire reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  // Configuration to the rest of the chip
  output logic [7:0] feature_cfg_out,
  output logic [7:0] charge_cfg_out,
  output logic [7:0] discharge_cfg_out,
  // Power state
  output logic regulator_drive_out,
  output logic awake_out,
  output logic asleep_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic is_wr(input reg_req_s req, input logic [7:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  logic [7:0] unlock_ff;
  logic [7:0] feature_cfg_ff;
  logic [7:0] charge_cfg_ff;
  logic [7:0] discharge_cfg_ff;
  logic sleep_ff;
  logic sleep_prev_ff;
  logic wake_status_ff;
  logic status_prev_ff;
  logic armed_ff;
  logic wake_prev_ff;
  logic regulator_ff;
  logic awake_ff;
  logic asleep_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  power_state_e state_ff;
  power_state_e nxt_state;

  logic por_hold;
  logic wake_act_raw;
  logic wake_filt;
  logic wake_rise;
  logic sleep_rise;
  logic host_sleep_fall;
  logic status_rise;
  logic sleep_go;

  // Supply loss or a forced reset clears everything
  assign por_hold = rst_in || !(backup_supply_ok_in && main_supply_ok_in) ||
                    feature_cfg_ff[FEAT_FORCE_POR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      unlock_ff <= REG_RESET;
    end else if (is_wr(reg_req_in, ADDR_UNLOCK)) begin
      unlock_ff <= reg_req_in.data & UNLOCK_RW_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      feature_cfg_ff <= REG_RESET;
    end else if (is_wr(reg_req_in, ADDR_FEATURE_CFG) && unlock_ff[UNLOCK_FEAT_BIT]) begin
      feature_cfg_ff <= reg_req_in.data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      charge_cfg_ff <= REG_RESET;
    end else if (is_wr(reg_req_in, ADDR_CHARGE_CFG) && unlock_ff[UNLOCK_CHARGE_BIT]) begin
      charge_cfg_ff <= reg_req_in.data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      discharge_cfg_ff <= REG_RESET;
    end else if (is_wr(reg_req_in, ADDR_DISCHARGE_CFG) && unlock_ff[UNLOCK_DISCH_BIT]) begin
      discharge_cfg_ff <= reg_req_in.data;
    end
  end

  // Read answers one cycle later; unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      rdata_ff <= REG_RESET;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        unique case (reg_req_in.addr)
          ADDR_DISCHARGE_CFG: rdata_ff <= discharge_cfg_ff;
          ADDR_CHARGE_CFG: rdata_ff <= charge_cfg_ff;
          ADDR_FEATURE_CFG: rdata_ff <= feature_cfg_ff;
          ADDR_UNLOCK: rdata_ff <= unlock_ff;
          ADDR_SLEEP_CTRL: rdata_ff <= {7'h00, sleep_ff};
          ADDR_WAKE_STATUS: rdata_ff <= {7'h00, wake_status_ff};
          default: rdata_ff <= REG_RESET;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake input

  assign wake_act_raw = !feature_cfg_ff[FEAT_WAKE_DISABLE_BIT] &&
                        (feature_cfg_ff[FEAT_WAKE_POL_BIT] ?
                         wake_input_in : !wake_input_in);

  wake_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_wake_filter (
    .clk_in(clk_in),
    .rst_in(por_hold),
    .active_raw_in(wake_act_raw),
    .active_out(wake_filt)
  );

  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      wake_prev_ff <= 1'b0;
    end else begin
      wake_prev_ff <= wake_filt;
    end
  end

  assign wake_rise = wake_filt && !wake_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep bit, arming and wake status

  assign sleep_rise = sleep_ff && !sleep_prev_ff;
  assign status_rise = wake_status_ff && !status_prev_ff;
  assign host_sleep_fall = is_wr(reg_req_in, ADDR_SLEEP_CTRL) && sleep_ff &&
                           !reg_req_in.data[SLEEP_BIT];

  // Host write wins over the hardware clear
  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      sleep_ff <= 1'b0;
    end else if (is_wr(reg_req_in, ADDR_SLEEP_CTRL)) begin
      sleep_ff <= reg_req_in.data[SLEEP_BIT];
    end else if (status_rise && sleep_ff) begin
      sleep_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      sleep_prev_ff <= 1'b0;
      status_prev_ff <= 1'b0;
    end else begin
      sleep_prev_ff <= sleep_ff;
      status_prev_ff <= wake_status_ff;
    end
  end

  // Latched at the end of pseudo-sleep; set wins over a write-one clear
  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      wake_status_ff <= 1'b0;
    end else if (state_ff == PSEUDO_SLEEP) begin
      wake_status_ff <= 1'b1;
    end else if (is_wr(reg_req_in, ADDR_WAKE_STATUS) && reg_req_in.data[WAKE_STATUS_BIT]) begin
      wake_status_ff <= 1'b0;
    end
  end

  // A host falling edge of the sleep bit lets the next rising edge act
  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      armed_ff <= 1'b0;
    end else if (host_sleep_fall) begin
      armed_ff <= 1'b1;
    end else if (wake_rise || sleep_go) begin
      armed_ff <= 1'b0;
    end
  end

  // Inactive wake pin arms directly
  assign sleep_go = (state_ff == AWAKE) && sleep_rise &&
                    (!wake_filt || armed_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Power state

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PWR_OFF: nxt_state = AWAKE;
      AWAKE: if (sleep_go) nxt_state = ASLEEP;
      ASLEEP: if (wake_rise) nxt_state = PSEUDO_SLEEP;
      PSEUDO_SLEEP: nxt_state = AWAKE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (por_hold) begin
      state_ff <= PWR_OFF;
      regulator_ff <= 1'b0;
      awake_ff <= 1'b0;
      asleep_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      regulator_ff <= (nxt_state == AWAKE) || (nxt_state == PSEUDO_SLEEP);
      awake_ff <= nxt_state == AWAKE;
      asleep_ff <= nxt_state == ASLEEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_out = rdata_ff;
  assign reg_rdata_valid_out = rvalid_ff;
  assign feature_cfg_out = feature_cfg_ff;
  assign charge_cfg_out = charge_cfg_ff;
  assign discharge_cfg_out = discharge_cfg_ff;
  assign regulator_drive_out = regulator_ff;
  assign awake_out = awake_ff;
  assign asleep_out = asleep_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_feat_lock;
    is_wr(reg_req_in, ADDR_FEATURE_CFG) && !unlock_ff[UNLOCK_FEAT_BIT] && !por_hold
      |=> feature_cfg_ff == $past(feature_cfg_ff);
  endproperty
  a_feat_lock: assert property (p_feat_lock) else $error("locked feature write took");

  property p_charge_lock;
    is_wr(reg_req_in, ADDR_CHARGE_CFG) && !por_hold
      |=> charge_cfg_ff == ($past(unlock_ff[UNLOCK_CHARGE_BIT]) ?
                            $past(reg_req_in.data) : $past(charge_cfg_ff));
  endproperty
  a_charge_lock: assert property (p_charge_lock) else $error("charge write gating wrong");

  property p_disch_lock;
    is_wr(reg_req_in, ADDR_DISCHARGE_CFG) && !unlock_ff[UNLOCK_DISCH_BIT] && !por_hold
      |=> $stable(discharge_cfg_ff);
  endproperty
  a_disch_lock: assert property (p_disch_lock) else $error("locked discharge write took");

  property p_unlock_por;
    por_hold |=> unlock_ff[UNLOCK_FEAT_BIT:UNLOCK_DISCH_BIT] == 3'h0;
  endproperty
  a_unlock_por: assert property (p_unlock_por) else $error("unlock bits not cleared");

  property p_flags_rw;
    is_wr(reg_req_in, ADDR_UNLOCK) && !por_hold
      |=> unlock_ff[FLAG_UPPER_BIT:FLAG_LOWER_BIT] ==
          $past(reg_req_in.data[FLAG_UPPER_BIT:FLAG_LOWER_BIT]);
  endproperty
  a_flags_rw: assert property (p_flags_rw) else $error("user flags not stored");

  property p_flags_keep;
    state_ff == ASLEEP && !por_hold && !is_wr(reg_req_in, ADDR_UNLOCK)
      |=> $stable(unlock_ff[FLAG_UPPER_BIT:FLAG_LOWER_BIT]);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("user flags lost in sleep");

  property p_reserved;
    unlock_ff[2:0] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_power_up;
    !por_hold && $past(por_hold) |=> state_ff == AWAKE && regulator_ff && awake_ff;
  endproperty
  a_power_up: assert property (p_power_up) else $error("no wake after power-up");

  property p_stay_awake;
    state_ff == AWAKE && !sleep_go && !por_hold |=> state_ff == AWAKE && regulator_ff;
  endproperty
  a_stay_awake: assert property (p_stay_awake) else $error("left awake state");

  property p_sleep_entry;
    state_ff == AWAKE && sleep_rise && !wake_filt && !por_hold
      |=> state_ff == ASLEEP && !regulator_ff && asleep_ff;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_sleep_blocked;
    state_ff == AWAKE && sleep_rise && wake_filt && !armed_ff && !por_hold
      |=> state_ff == AWAKE;
  endproperty
  a_sleep_blocked: assert property (p_sleep_blocked) else $error("unarmed sleep taken");

  property p_wake_seq;
    state_ff == ASLEEP && wake_rise && !por_hold ##1 !por_hold
      |=> state_ff == AWAKE && wake_status_ff && $past(regulator_ff) && !$past(awake_ff);
  endproperty
  a_wake_seq: assert property (p_wake_seq) else $error("wake skipped pseudo-sleep");

  property p_status_clears_sleep;
    status_rise && sleep_ff && !por_hold && !is_wr(reg_req_in, ADDR_SLEEP_CTRL)
      |=> !sleep_ff;
  endproperty
  a_status_clears_sleep: assert property (p_status_clears_sleep) else $error("sleep bit kept");

  property p_wake_disable;
    state_ff == ASLEEP && feature_cfg_ff[FEAT_WAKE_DISABLE_BIT] &&
    $past(feature_cfg_ff[FEAT_WAKE_DISABLE_BIT]) && !por_hold |=> state_ff == ASLEEP;
  endproperty
  a_wake_disable: assert property (p_wake_disable) else $error("woke while pin disabled");

  c_sleep: cover property (state_ff == AWAKE && sleep_go);
  c_wake: cover property (state_ff == PSEUDO_SLEEP ##1 state_ff == AWAKE);
  c_rearm: cover property (host_sleep_fall && wake_filt);
  c_force_por: cover property (feature_cfg_ff[FEAT_FORCE_POR_BIT]);

endmodule

/* test/host_model.sv */
// Host microcontroller and wake-pin circuitry facing the sleep and lock block.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/10ps
module host_model
  import sleep_wake_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Read return
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  // Requests and wake pin
  output reg_req_s req_out,
  output logic wake_pin_out
);
  initial begin
    req_out = '0;
    wake_pin_out = 1'b1;
  end

  // One request held through its sampling edge; released lines show inverted values
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                        output logic [7:0] rdata);
    @(posedge clk_in);
    #2;
    req_out = '{wr: wr, rd: !wr, addr: addr, data: data};
    @(posedge clk_in);
    #2;
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
    rdata = (wr || rvalid_in === 1'b1) ? rdata_in : 8'hxx;
  endtask

  // Sleep bit falling edge before the next rising edge
  task automatic rearm_sleep();
    logic [7:0] unused;
    access(1'b1, ADDR_SLEEP_CTRL, 8'h00, unused);
    access(1'b1, ADDR_SLEEP_CTRL, 8'h01, unused);
  endtask

  // Wake pin level, held for a number of cycles
  task automatic set_pin(input logic level, input int hold);
    @(posedge clk_in);
    #2;
    wake_pin_out = level;
    repeat (hold) @(posedge clk_in);
  endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the sleep, wake and configuration lock block.
// Assumes host_model drives the register port and the wake pin.
`timescale 1ns/10ps
module testbench;
  import sleep_wake_pkg::*;
  localparam int FILT = 4;
  logic clk_in, rst_in, backup_ok, main_ok, wake_pin, rvalid, reg_on, awake, asleep;
  logic [7:0] rdata, feat, chg, dis, rd, u, v;
  logic [7:0] shadow [3];
  logic [7:0] lk [4];
  reg_req_s req;
  int err_total, samples_checked, cycles;

  sleep_wake_and_write_lock #(.FILTER_CYCLES(FILT)) sleep_wake_and_write_lock_i (
    .clk_in(clk_in), .rst_in(rst_in), .backup_supply_ok_in(backup_ok),
    .main_supply_ok_in(main_ok), .wake_input_in(wake_pin), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rdata_valid_out(rvalid), .feature_cfg_out(feat),
    .charge_cfg_out(chg), .discharge_cfg_out(dis), .regulator_drive_out(reg_on),
    .awake_out(awake), .asleep_out(asleep));

  host_model host_model_i (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .req_out(req), .wake_pin_out(wake_pin));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Power state packed as regulator, awake, asleep
  function automatic logic [7:0] pwr(input logic r, input logic a, input logic s);
    return {5'h00, r, a, s};
  endfunction

  // Wait for full wake, noting whether pseudo-sleep came first
  task automatic expect_wake();
    logic pseudo;
    pseudo = 1'b0;
    for (int n = 0; n < 3 * FILT + 8 && awake !== 1'b1; n++) begin
      @(posedge clk_in);
      #2;
      if (reg_on === 1'b1 && awake === 1'b0 && asleep === 1'b0) pseudo = 1'b1;
    end
    check({7'h00, pseudo}, 8'h01);
    check(pwr(reg_on, awake, asleep), pwr(1'b1, 1'b1, 1'b0));
    repeat (2) @(posedge clk_in);
    host_model_i.access(1'b0, ADDR_SLEEP_CTRL, 8'h00, rd);
    check(rd, 8'h00);
    // Host software clears the latched status so the next wake makes a new rising edge
    host_model_i.access(1'b0, ADDR_WAKE_STATUS, 8'h00, rd);
    check(rd, 8'h01);
    host_model_i.access(1'b1, ADDR_WAKE_STATUS, 8'h01, rd);
  endtask

  task automatic sleep_now();
    host_model_i.access(1'b1, ADDR_SLEEP_CTRL, 8'h01, rd);
    repeat (2) @(posedge clk_in);
    #2;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    rst_in = 1'b1;
    backup_ok = 1'b1;
    main_ok = 1'b1;
    lk = '{8'h00, 8'h80, 8'h40, 8'h20};
    shadow = '{8'h00, 8'h00, 8'h00};
    void'($urandom(32'hcad6));
    repeat (2) @(posedge clk_in);
    #2;
    rst_in = 1'b0;
    @(posedge clk_in);
    #2;
    check(pwr(reg_on, awake, asleep), pwr(1'b1, 1'b1, 1'b0));
    host_model_i.access(1'b0, ADDR_UNLOCK, 8'h00, rd);
    check(rd, REG_RESET);
    // Each unlock bit alone, with random flags and reserved bits
    for (int i = 0; i < 4; i++) begin
      u = lk[i] | 8'($urandom & 32'h1f);
      host_model_i.access(1'b1, ADDR_UNLOCK, u, rd);
      host_model_i.access(1'b0, ADDR_UNLOCK, 8'h00, rd);
      check(rd, u & UNLOCK_RW_MASK);
      for (int a = 0; a < 3; a++) begin
        v = 8'($urandom) & 8'hf8;
        host_model_i.access(1'b1, ADDR_FEATURE_CFG - 8'(a), v, rd);
        if (u[7 - a]) shadow[a] = v;
      end
      check(feat, shadow[0]);
      check(chg, shadow[1]);
      check(dis, shadow[2]);
    end
    // Active-low wake: sleep with pin idle, glitch, then real wake
    sleep_now();
    check(pwr(reg_on, awake, asleep), pwr(1'b0, 1'b0, 1'b1));
    // A level is sampled hold + 1 times, so this glitch is one sample short of the filter
    host_model_i.set_pin(1'b0, FILT - 2);
    host_model_i.set_pin(1'b1, 3 * FILT);
    #2;
    check(pwr(reg_on, awake, asleep), pwr(1'b0, 1'b0, 1'b1));
    host_model_i.set_pin(1'b0, 0);
    expect_wake();
    host_model_i.access(1'b0, ADDR_UNLOCK, 8'h00, rd);
    check(rd, u & UNLOCK_RW_MASK);
    // Pin still active: plain rise refused, re-armed rise accepted
    sleep_now();
    repeat (4) @(posedge clk_in);
    #2;
    check(pwr(reg_on, awake, asleep), pwr(1'b1, 1'b1, 1'b0));
    host_model_i.rearm_sleep();
    repeat (2) @(posedge clk_in);
    #2;
    check(pwr(reg_on, awake, asleep), pwr(1'b0, 1'b0, 1'b1));
    host_model_i.set_pin(1'b1, FILT + 2);
    host_model_i.set_pin(1'b0, 0);
    expect_wake();
    // Active-high wake
    host_model_i.access(1'b1, ADDR_UNLOCK, 8'h80, rd);
    host_model_i.access(1'b1, ADDR_FEATURE_CFG, 8'h01, rd);
    repeat (FILT + 4) @(posedge clk_in);
    sleep_now();
    check(pwr(reg_on, awake, asleep), pwr(1'b0, 1'b0, 1'b1));
    host_model_i.set_pin(1'b1, 0);
    expect_wake();
    // Wake pin disabled: only clearing the disable bit wakes
    host_model_i.access(1'b1, ADDR_FEATURE_CFG, 8'h03, rd);
    host_model_i.set_pin(1'b0, FILT + 4);
    sleep_now();
    host_model_i.set_pin(1'b1, 3 * FILT + 8);
    #2;
    check(pwr(reg_on, awake, asleep), pwr(1'b0, 1'b0, 1'b1));
    host_model_i.access(1'b1, ADDR_FEATURE_CFG, 8'h01, rd);
    expect_wake();
    // Loss of either supply, or a forced reset, clears everything; return powers up locked
    for (int s = 0; s < 3; s++) begin
      @(posedge clk_in);
      #2;
      if (s == 0) begin
        backup_ok = 1'b0;
      end else if (s == 1) begin
        main_ok = 1'b0;
      end else begin
        host_model_i.access(1'b1, ADDR_UNLOCK, 8'h80, rd);
        host_model_i.access(1'b1, ADDR_FEATURE_CFG, 8'h04, rd);
      end
      @(posedge clk_in);
      #2;
      check(pwr(reg_on, awake, asleep) | feat, 8'h00);
      backup_ok = 1'b1;
      main_ok = 1'b1;
      @(posedge clk_in);
      #2;
      check(pwr(reg_on, awake, asleep), pwr(1'b1, 1'b1, 1'b0));
      host_model_i.access(1'b0, ADDR_UNLOCK, 8'h00, rd);
      check(rd, REG_RESET);
    end
    final_report();
  end
endmodule
